/* src/pmr_pkg.sv */
package pmr_pkg;

    // Register byte offsets.
    localparam logic [11:0] PMR_OFF_PWR_CTL_STS = 12'h0C4;
    localparam logic [11:0] PMR_OFF_MSG_CAP_CTL = 12'h0D0;
    localparam logic [11:0] PMR_OFF_MSG_ADDR_LO = 12'h0D4;
    localparam logic [11:0] PMR_OFF_MSG_ADDR_HI = 12'h0D8;
    localparam logic [11:0] PMR_OFF_MSG_DATA = 12'h0DC;

    // Power control and status field positions.
    localparam int PMR_PS_LSB = 0;
    localparam int PMR_KEEP_BIT = 3;
    localparam int PMR_WEN_BIT = 8;
    localparam int PMR_WFLAG_BIT = 15;

    // Power state encodings.
    localparam logic [1:0] PMR_PS_D0 = 2'h0;
    localparam logic [1:0] PMR_PS_D1 = 2'h1;
    localparam logic [1:0] PMR_PS_D2 = 2'h2;
    localparam logic [1:0] PMR_PS_D3HOT = 2'h3;

    // Capability header fields.
    localparam logic [7:0] PMR_CAP_TAG = 8'h05;
    localparam logic [7:0] PMR_NEXT_LINK_RST = 8'h00;
    localparam int PMR_NEXT_LSB = 8;
    localparam int PMR_MEN_BIT = 16;
    localparam int PMR_VCG_LSB = 20;
    localparam int PMR_WIDE_BIT = 23;
    localparam logic PMR_KEEP_RST = 1'b1;
    localparam logic [2:0] PMR_VCG_RST = 3'h0;

    // Control register bits (lock for lockable-writable fields).
    localparam int PMR_LOCK_BIT = 0;

    localparam int PMR_ADDR_LSB = 2;

    // Interrupt memory write request.
    typedef struct packed {
        logic wide;
        logic [31:0] addr_hi;
        logic [31:0] addr_lo;
        logic [15:0] payload;
    } pmr_msg_wr_t;

endpackage

/* src/pmr_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module pmr_regs
    import pmr_pkg::*;
#(
    parameter bit IS_UPSTREAM = 1'b0
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hot_reset,
    input wire logic cfg_lock,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_event,
    input wire logic wake_forward,
    input wire logic msg_event,
    output logic wake_msg_req,
    output logic msg_wr_valid,
    output pmr_msg_wr_t msg_wr,
    output logic msg_to_upstream,
    output logic [1:0] power_state_field
);

    logic [1:0] ps_ff;
    logic keep_ff;
    logic wen_ff;
    logic wflag_ff;
    logic [7:0] next_ff;
    logic men_ff;
    logic [2:0] vcg_ff;
    logic [29:0] alo_ff;
    logic [31:0] ahi_ff;
    logic [15:0] pay_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic wake_req_ff;
    logic mv_ff;
    pmr_msg_wr_t mw_ff;

    // Storage overview.
    // The power state, context keep flag and wake bits live in one word.
    // The capability word carries the tag, next link, enable and count.
    // The lower address keeps only the word-aligned upper thirty bits.
    // The upper address and payload words sit just past the lower address.
    // Every bit that has no storage here reads back as a fixed value.
    // Fixed values are produced in the read view, not stored in flops.
    // This keeps the flop count down and makes read-only bits immune
    // to any write, whatever data the bus presents.
    // The wake enable and wake flag are kept apart from the other fields.
    // They must survive a hot reset, so they have a process of their own.
    // All other writable fields fall back to their reset values on a
    // hot reset as well as on the asynchronous reset.
    // The outgoing request pulses are registered so that every output
    // of this block comes straight from a flip-flop.

    // Bus handshake notes.
    // A setup cycle is recognised while the slave is not already answering.
    // The answer flop then raises ready for exactly the access cycle.
    // Read data is captured from the setup cycle, while the address is
    // already stable, so the access cycle only presents stored data.
    // A write lands at the edge that closes the access cycle, which is
    // the same edge at which the master samples ready high.
    // An address outside the map answers with an error and no effect.
    // Back-to-back transfers work because ready drops after one cycle,
    // which lets the next setup cycle be seen at once.
    //
    // Bus decode; no wait state, answer registered.
    wire setup = psel && !penable && !pready_ff;
    wire acc = psel && penable && pready_ff;
    wire wr = acc && pwrite;
    wire sel_pcs = paddr == PMR_OFF_PWR_CTL_STS;
    wire sel_cap = paddr == PMR_OFF_MSG_CAP_CTL;
    wire sel_alo = paddr == PMR_OFF_MSG_ADDR_LO;
    wire sel_ahi = paddr == PMR_OFF_MSG_ADDR_HI;
    wire sel_dat = paddr == PMR_OFF_MSG_DATA;
    wire hit = sel_pcs | sel_cap | sel_alo | sel_ahi | sel_dat;
    wire [1:0] wps = pwdata[PMR_PS_LSB +: 2];
    wire ps_ok = (wps == PMR_PS_D0) || (wps == PMR_PS_D3HOT);
    wire own_wake = wake_event && !IS_UPSTREAM;
    wire wclr = wr && sel_pcs && pwdata[PMR_WFLAG_BIT];

    // Read view notes.
    // The power word shows the state, keep flag, wake enable and flag.
    // Data select, data scale, data and bus power bits stay zero.
    // The capability word shows a constant tag and a fixed wide flag.
    // The requested message count stays zero, meaning one message.
    // The granted count is stored and shown but never used, since one
    // message is always sent whatever software grants.
    // The lower address shows zero in its two lowest bits.
    // The payload word shows zero in its upper half.
    //
    // Read views; unlisted bits are fixed zero.
    logic [31:0] v_pcs;
    logic [31:0] v_cap;
    logic [31:0] rd_mux;
    always_comb
    begin
        v_pcs = '0;
        v_pcs[PMR_PS_LSB +: 2] = ps_ff;
        v_pcs[PMR_KEEP_BIT] = keep_ff;
        v_pcs[PMR_WEN_BIT] = wen_ff;
        v_pcs[PMR_WFLAG_BIT] = wflag_ff;
        v_cap = '0;
        v_cap[7:0] = PMR_CAP_TAG;
        v_cap[PMR_NEXT_LSB +: 8] = next_ff;
        v_cap[PMR_MEN_BIT] = men_ff;
        v_cap[PMR_VCG_LSB +: 3] = vcg_ff;
        v_cap[PMR_WIDE_BIT] = 1'b1;
        rd_mux = '0;
        if (sel_pcs)
            rd_mux = v_pcs;
        else if (sel_cap)
            rd_mux = v_cap;
        else if (sel_alo)
            rd_mux = {alo_ff, 2'b00};
        else if (sel_ahi)
            rd_mux = ahi_ff;
        else if (sel_dat)
            rd_mux = {16'h0000, pay_ff};
    end

    // Bus handshake and read data.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end
        else
        begin
            pready_ff <= setup;
            pslverr_ff <= setup && !hit;
            prdata_ff <= (setup && !pwrite) ? rd_mux : '0;
        end
    end

    // Wake bit notes.
    // The enable is written from the power word like any other field.
    // The flag is set by a wake that this port itself originates, even
    // while the enable is clear, so software can see a missed wake.
    // A wake that is merely forwarded through the port never sets it.
    // An upstream port never originates a wake, so its flag stays zero.
    // When an own wake and a write-one clear meet in one cycle, the set
    // wins, so that a wake is never lost to a racing clear.
    //
    // Sticky wake bits survive hot reset; only presetn clears them.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wen_ff <= 1'b0;
            wflag_ff <= 1'b0;
        end
        else
        begin
            if (wr && sel_pcs)
                wen_ff <= pwdata[PMR_WEN_BIT];
            // Set wins over clear; forwarded wakes do not touch it.
            if (own_wake)
                wflag_ff <= 1'b1;
            else if (wclr)
                wflag_ff <= 1'b0;
        end
    end

    // Field write notes.
    // A power state write of D1 or D2 leaves the field unchanged; only D0 and D3hot are taken.
    // The keep flag and next link ignore writes while the lock is high.
    // The interrupt enable and granted count have no lock.
    // The address and payload words take any value software writes.
    //
    // Non-sticky registers, cleared by hot reset too.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ps_ff <= PMR_PS_D0;
            keep_ff <= PMR_KEEP_RST;
            next_ff <= PMR_NEXT_LINK_RST;
            men_ff <= 1'b0;
            vcg_ff <= PMR_VCG_RST;
            alo_ff <= '0;
            ahi_ff <= '0;
            pay_ff <= '0;
        end
        else if (hot_reset)
        begin
            ps_ff <= PMR_PS_D0;
            keep_ff <= PMR_KEEP_RST;
            next_ff <= PMR_NEXT_LINK_RST;
            men_ff <= 1'b0;
            vcg_ff <= PMR_VCG_RST;
            alo_ff <= '0;
            ahi_ff <= '0;
            pay_ff <= '0;
        end
        else if (wr)
        begin
            if (sel_pcs && ps_ok)
                ps_ff <= wps;
            if (sel_pcs && !cfg_lock)
                keep_ff <= pwdata[PMR_KEEP_BIT];
            if (sel_cap && !cfg_lock)
                next_ff <= pwdata[PMR_NEXT_LSB +: 8];
            if (sel_cap)
            begin
                men_ff <= pwdata[PMR_MEN_BIT];
                vcg_ff <= pwdata[PMR_VCG_LSB +: 3];
            end
            if (sel_alo)
                alo_ff <= pwdata[31:PMR_ADDR_LSB];
            if (sel_ahi)
                ahi_ff <= pwdata;
            if (sel_dat)
                pay_ff <= pwdata[15:0];
        end
    end

    // Request notes.
    // A wake message leaves only for an own wake while enable is set.
    // An interrupt write leaves only for an event while enabled.
    // The write carries the programmed address and payload, and it is
    // marked wide whenever the upper address word is not zero.
    // Every interrupt write is routed towards the upstream port, so
    // software must program only addresses that route that way.
    // The request fields are refreshed every cycle; they are meaningful
    // only in the cycle in which the valid pulse stands.
    //
    // Outgoing wake and interrupt write requests, one-cycle pulses.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_req_ff <= 1'b0;
            mv_ff <= 1'b0;
            mw_ff <= '0;
        end
        else
        begin
            wake_req_ff <= own_wake && wen_ff;
            mv_ff <= msg_event && men_ff;
            mw_ff.wide <= ahi_ff != '0;
            mw_ff.addr_hi <= ahi_ff;
            mw_ff.addr_lo <= {alo_ff, 2'b00};
            mw_ff.payload <= pay_ff;
        end
    end

    // Output notes.
    // Each output below is a plain copy of a flop, with no logic after it.
    // The routing flag equals the valid pulse, since all writes go up.
    // The power state is exported as a level for the rest of the port.
    //
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign wake_msg_req = wake_req_ff;
    assign msg_wr_valid = mv_ff;
    assign msg_wr = mw_ff;
    assign msg_to_upstream = mv_ff;
    assign power_state_field = ps_ff;

endmodule // pmr_regs
`default_nettype wire

/* verif/pmr_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module pmr_checker
    import pmr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic wake_event,
    input wire logic msg_event,
    input wire logic wake_msg_req,
    input wire logic msg_wr_valid,
    input wire pmr_msg_wr_t msg_wr,
    input wire logic msg_to_upstream,
    input wire logic [1:0] power_state_field
);
    // All checks run on the bus clock and rest while reset is low.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Read answers of the power word and the capability word.
    wire rd_ps = pready && !pwrite && paddr == PMR_OFF_PWR_CTL_STS;
    wire rd_cap = pready && !pwrite && paddr == PMR_OFF_MSG_CAP_CTL;
    answer_a: assert property (psel && !penable |=> pready)
        else $error("no pready");
    state_a: assert property (power_state_field inside {2'h0, 2'h3})
        else $error("reserved state");
    ps_ro_a: assert property (rd_ps |-> prdata[31:22] == 10'h0
        && prdata[14:9] == 6'h0 && prdata[1:0] == power_state_field)
        else $error("power word bad");
    cap_a: assert property (rd_cap |-> prdata[7:0] == PMR_CAP_TAG
        && prdata[23] && prdata[19:17] == 3'h0)
        else $error("cap word bad");
    wake_a: assert property (wake_msg_req |-> $past(wake_event))
        else $error("stray wake");
    msg_a: assert property (msg_wr_valid |-> $past(msg_event))
        else $error("stray write");
    route_a: assert property (msg_to_upstream == msg_wr_valid)
        else $error("not routed");
    wide_a: assert property (msg_wr_valid |->
        msg_wr.wide == (msg_wr.addr_hi != 32'h0))
        else $error("wide bad");
    align_a: assert property (msg_wr_valid |-> msg_wr.addr_lo[1:0] == 2'h0)
        else $error("addr unaligned");
    cover property (wake_msg_req);
    cover property (msg_wr_valid && msg_wr.wide);
    cover property (rd_cap);
endmodule // pmr_checker
`default_nettype wire

/* verif/pmr_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module pmr_regs_tb
    import pmr_pkg::*;
    ();
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic err;
    } pmr_row_t;
    // Rows: write flag, address, write data, read-back, error.
    localparam pmr_row_t ROWS [12] = '{
        '{1'h0, 12'h0C4, 32'h0, 32'h0000_0008, 1'h0},
        '{1'h0, 12'h0D0, 32'h0, 32'h0080_0005, 1'h0},
        '{1'h0, 12'h0D4, 32'h0, 32'h0, 1'h0},
        '{1'h1, 12'h0C4, 32'hFFFF_7F03, 32'h0000_0103, 1'h0},
        '{1'h1, 12'h0C4, 32'h0000_0102, 32'h0000_0103, 1'h0},
        '{1'h1, 12'h0C4, 32'h0000_0101, 32'h0000_0103, 1'h0},
        '{1'h1, 12'h0C4, 32'h0000_0100, 32'h0000_0100, 1'h0},
        '{1'h1, 12'h0C4, 32'h0000_0003, 32'h0000_0003, 1'h0},
        '{1'h1, 12'h0D0, 32'hFFFF_FFFF, 32'h00F1_FF05, 1'h0},
        '{1'h1, 12'h0D4, 32'hFFFF_FFFF, 32'hFFFF_FFFC, 1'h0},
        '{1'h1, 12'h0DC, 32'hFFFF_1234, 32'h0000_1234, 1'h0},
        '{1'h1, 12'h0E0, 32'hFFFF_FFFF, 32'h0, 1'h1}};
    logic pclk, presetn, hot_reset, cfg_lock, wake_event, wake_forward;
    logic msg_event, psel, penable, pwrite, pready, pslverr, wake_msg_req;
    logic msg_wr_valid, msg_to_upstream, late, err, wake_req_up;
    logic [1:0] power_state_field;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    pmr_msg_wr_t msg_wr;
    int num_errors = 0;
    int num_checks = 0;
    pmr_regs u_pmr_regs (.pclk(pclk), .presetn(presetn),
        .hot_reset(hot_reset), .cfg_lock(cfg_lock), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wake_event(wake_event), .wake_forward(wake_forward),
        .msg_event(msg_event), .wake_msg_req(wake_msg_req),
        .msg_wr_valid(msg_wr_valid), .msg_wr(msg_wr),
        .msg_to_upstream(msg_to_upstream),
        .power_state_field(power_state_field));
    // Upstream flavour shares the bus writes; only its wake pulse is read.
    pmr_regs #(.IS_UPSTREAM(1'b1)) u_pmr_regs_up (.pclk(pclk),
        .presetn(presetn), .hot_reset(hot_reset), .cfg_lock(cfg_lock),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .wake_event(wake_event), .wake_forward(wake_forward),
        .msg_event(msg_event), .wake_msg_req(wake_req_up),
        .msg_wr_valid(), .msg_wr(), .msg_to_upstream(),
        .power_state_field());
    pmr_root u_pmr_root (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // Free-running bus clock.
    initial
    begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    task automatic close_out();
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s,
        input logic [31:0] x);
        num_checks++;
        if (s !== x)
        begin
            num_errors++;
            $display("MISMATCH %s exp %h saw %h", n, x, s);
        end
    endtask
    // One access with its error compared, and its read data too on a read.
    task automatic io(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] x, input logic xe);
        u_pmr_root.xfer(w, a, d, rd, err, late);
        if (late)
        begin
            num_errors++;
            close_out();
        end
        else
        begin
            chk("pslverr", {31'h0, err}, {31'h0, xe});
            if (!w)
                chk("prdata", rd, x);
        end
    endtask
    // Pulses an event for one cycle and waits until it is taken.
    // Event codes: 0 own wake, 1 forwarded wake, 2 interrupt, 3 hot reset.
    task automatic tick(input int k);
        @(posedge pclk);
        case (k)
            0: wake_event <= 1'h1;
            1: wake_forward <= 1'h1;
            2: msg_event <= 1'h1;
            default: hot_reset <= 1'h1;
        endcase
        @(posedge pclk);
        {wake_event, wake_forward, msg_event, hot_reset} <= 4'h0;
        #1;
    endtask
    initial
    begin
        {presetn, hot_reset, cfg_lock, wake_event, wake_forward} = 5'h0;
        msg_event = 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        foreach (ROWS[i])
        begin
            if (ROWS[i].w)
                io(1'h1, ROWS[i].a, ROWS[i].d, 32'h0, ROWS[i].err);
            io(1'h0, ROWS[i].a, 32'h0, ROWS[i].e, ROWS[i].err);
        end
        tick(0);
        chk("wake_msg_req", {31'h0, wake_msg_req}, 32'h0);
        io(1'h0, 12'h0C4, 32'h0, 32'h0000_8003, 1'h0);
        io(1'h1, 12'h0C4, 32'h0000_8103, 32'h0, 1'h0);
        tick(1);
        io(1'h0, 12'h0C4, 32'h0, 32'h0000_0103, 1'h0);
        tick(0);
        chk("wake_msg_req", {31'h0, wake_msg_req}, 32'h1);
        chk("wake_up", {31'h0, wake_req_up}, 32'h0);
        tick(2);
        chk("addr_lo", msg_wr.addr_lo, 32'hFFFF_FFFC);
        chk("to_upstream", {31'h0, msg_to_upstream}, 32'h1);
        chk("payload", {15'h0, msg_wr_valid, msg_wr.payload}, 32'h0001_1234);
        chk("addr_hi", {msg_wr.wide, msg_wr.addr_hi[30:0]}, 32'h0);
        io(1'h1, 12'h0D8, 32'h0000_0001, 32'h0, 1'h0);
        tick(2);
        chk("addr_hi", {msg_wr.wide, msg_wr.addr_hi[30:0]}, 32'h8000_0001);
        io(1'h1, 12'h0D0, 32'h0, 32'h0, 1'h0);
        tick(2);
        chk("msg_wr_valid", {31'h0, msg_wr_valid}, 32'h0);
        cfg_lock <= 1'h1;
        io(1'h1, 12'h0D0, 32'h0000_FF00, 32'h0, 1'h0);
        io(1'h0, 12'h0D0, 32'h0, 32'h0080_0005, 1'h0);
        io(1'h1, 12'h0C4, 32'h0000_010B, 32'h0, 1'h0);
        io(1'h0, 12'h0C4, 32'h0, 32'h0000_8103, 1'h0);
        cfg_lock <= 1'h0;
        tick(3);
        chk("power_state", {30'h0, power_state_field}, 32'h0);
        io(1'h0, 12'h0C4, 32'h0, 32'h0000_8108, 1'h0);
        close_out();
    end
endmodule // pmr_regs_tb
bind pmr_regs pmr_checker u_pmr_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .wake_event(wake_event),
    .msg_event(msg_event), .wake_msg_req(wake_msg_req),
    .msg_wr_valid(msg_wr_valid), .msg_wr(msg_wr),
    .msg_to_upstream(msg_to_upstream),
    .power_state_field(power_state_field));
`default_nettype wire

/* verif/pmr_root.sv */
`timescale 1ns/100ps
`default_nettype none
module pmr_root
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // The bus idles at time zero.
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    end
    // One configuration access; late is set if pready never comes.
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err,
        output logic late);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        late = 1'h1;
        for (n = 0; n < 16 && late; n++)
        begin
            @(posedge pclk);
            late = !pready;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // pmr_root
`default_nettype wire
